//--- bench/led_sink_error_detect_tb.sv
// Self-checking bench for the LED sink driver core.
`timescale 1ns/1ns
`define CHK(n, e, g) check_eq(n, e, g)
module led_sink_error_detect_tb
    import lsed_pkg::*;
;
    typedef struct {lsed_word_t d, o, s, r;} lsed_row_s; // One case.
    logic       clk, rst, serial_clk, serial_in, latch_strobe, gate_n;
    logic       serial_out, in_ready;
    lsed_word_t open_cmp, short_cmp, sink_output, got;
    int         n_fail, checks;
    // Comparators are static: a faulty load sits past its threshold.
    // Columns: display data, open flags, short flags, expected read-back.
    lsed_row_s  rows [4] = '{
        '{16'ha5c3, 16'h0000, 16'h0000, 16'ha5c3},
        '{16'hffff, 16'h8001, 16'h0000, 16'h7ffe},
        '{16'h0000, 16'h0000, 16'hc002, 16'hc002},
        '{16'hf00f, 16'h1108, 16'h0180, 16'he187}};
    lsed_top DUT (.clk(clk), .rst(rst), .serial_clk(serial_clk),
        .serial_in(serial_in), .latch_strobe(latch_strobe),
        .gate_n(gate_n), .open_cmp(open_cmp), .short_cmp(short_cmp),
        .sink_output(sink_output), .serial_out(serial_out),
        .in_ready(in_ready));
    lsed_ctrl_model u_ctrl (.clk(clk), .serial_out(serial_out),
        .serial_clk(serial_clk), .serial_in(serial_in),
        .latch_strobe(latch_strobe), .gate_n(gate_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // A hang ends the run as a mismatch.
    initial begin
        #1000000;
        n_fail++;
        $display("BAD watchdog exp finish got hang");
        test_done();
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check_eq(input string n, input lsed_word_t e, g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
    endtask
    task automatic settle();
        repeat (10) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        open_cmp = 16'h0000;
        short_cmp = 16'h0000;
        n_fail = 0;
        checks = 0;
        do_reset();
        `CHK("sink", 16'h0000, sink_output);
        `CHK("sout", 16'h0000, lsed_word_t'(serial_out));
        `CHK("ready", 16'h0001, lsed_word_t'(in_ready));
        $display("reset values done");
        u_ctrl.set_gate(1'b0);
        foreach (rows[i]) begin
            @(posedge clk);
            open_cmp <= rows[i].o;
            short_cmp <= rows[i].s;
            u_ctrl.shift_word(rows[i].d, got);
            u_ctrl.pulse_latch();
            settle();
            `CHK("sink", rows[i].d, sink_output);
            u_ctrl.shift_word(16'h0000, got);
            `CHK("readback", rows[i].r, got);
            $display("row %0d done", i);
        end
        // Gate off: nothing sinks and an open load goes unreported.
        u_ctrl.set_gate(1'b1);
        @(posedge clk);
        open_cmp <= 16'hffff;
        short_cmp <= 16'h0000;
        u_ctrl.shift_word(16'hffff, got);
        u_ctrl.pulse_latch();
        settle();
        `CHK("gated sink", 16'h0000, sink_output);
        u_ctrl.set_gate(1'b0); // One 100 ns pulse, too short to judge.
        u_ctrl.set_gate(1'b1);
        u_ctrl.shift_word(16'hffff, got);
        `CHK("short gate", 16'hffff, got);
        u_ctrl.set_gate(1'b0);
        settle();
        u_ctrl.shift_word(16'h0000, got);
        `CHK("late open", 16'h0000, got);
        $display("gate test done");
        do_reset();
        `CHK("reset sink", 16'h0000, sink_output);
        u_ctrl.shift_word(16'h0000, got);
        `CHK("reset shift", 16'h0000, got);
        $display("reset test done");
        test_done();
    end
endmodule // led_sink_error_detect_tb

//--- bench/lsed_ctrl_model.sv
// Display controller model driving the shift, latch and gate pins.
`timescale 1ns/1ns
module lsed_ctrl_model
    import lsed_pkg::*;
(
    input  wire logic clk,          // System clock.
    input  wire logic serial_out,   // Data back from the chain.
    output logic      serial_clk,   // Shift clock, idle low.
    output logic      serial_in,    // Serial data.
    output logic      latch_strobe, // Latch strobe, idle low.
    output logic      gate_n        // Output gate, idle off.
);
    initial begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        latch_strobe = 1'b0;
        gate_n = 1'b1;
    end
    // MSB first; the high phase is 4 clocks and the low phase 4, not below the 3 the core needs.
    task automatic shift_word(input lsed_word_t d, output lsed_word_t q);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk);
            q[i] = serial_out;
            serial_in <= d[i];
            @(posedge clk);
            serial_clk <= 1'b1;
            repeat (4) @(posedge clk);
            serial_clk <= 1'b0;
            @(posedge clk);
            serial_in <= ~d[i]; // Released data does not keep its value.
            @(posedge clk);
        end
    endtask
    // Strobe held 3 clocks so outputs settle before they are judged.
    task automatic pulse_latch();
        repeat (5) @(posedge clk);
        latch_strobe <= 1'b1;
        repeat (3) @(posedge clk);
        latch_strobe <= 1'b0;
    endtask
    task automatic set_gate(input logic v);
        @(posedge clk);
        gate_n <= v;
    endtask
endmodule // lsed_ctrl_model

//--- bench/lsed_properties.sv
// Port assertions for the LED sink driver core.
`timescale 1ns/1ns
module lsed_properties (
    input wire logic        clk,          // Clock.
    input wire logic        rst,          // Reset, high.
    input wire logic        serial_clk,   // Shift pin.
    input wire logic        latch_strobe, // Latch pin.
    input wire logic        gate_n,       // Gate pin, low on.
    input wire logic [15:0] open_cmp,     // Open flags.
    input wire logic [15:0] short_cmp,    // Short flags.
    input wire logic [15:0] sink_output,  // Sinks.
    input wire logic        serial_out,   // Last stage.
    input wire logic        in_ready      // Buffer room.
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Shift pin idle long enough that no bit is still in the pipe.
    sequence s_calm;
        !serial_clk [*6];
    endsequence
    // A load, then a gated settle window with condition c held.
    sequence s_load(c);
        $rose(latch_strobe) ##0 (c && !gate_n && !serial_clk) [*8];
    endsequence
    a_reset_clean: assert property (
        $fell(rst) |-> sink_output == 16'h0000 && !serial_out && in_ready)
        else $error("reset values wrong");
    a_gate_blocks: assert property (
        gate_n [*5] |-> sink_output == 16'h0000)
        else $error("sink on while gated off");
    a_sink_steady: assert property (
        (!latch_strobe && $stable(gate_n)) [*6] |=> $stable(sink_output))
        else $error("sink moved without cause");
    a_shift_quiet: assert property (
        (!serial_clk && !latch_strobe && $stable(gate_n)) [*8]
        |=> $stable(serial_out))
        else $error("serial out moved without cause");
    // The buffer pops every cycle in which no fault is written, so a full state cannot last.
    a_ready_back: assert property (!in_ready |-> ##[1:8] in_ready)
        else $error("buffer stuck full");
    a_short_report: assert property (
        s_calm ##1 s_load(short_cmp[15]) |-> sink_output[15] || serial_out)
        else $error("short not reported");
    a_open_report: assert property (
        s_calm ##1 s_load(open_cmp[15] && !short_cmp[15]) |-> !serial_out)
        else $error("open not reported");
    a_clean_agree: assert property (
        s_calm ##1 s_load(!open_cmp[15] && !short_cmp[15])
        |-> serial_out == sink_output[15])
        else $error("sink and shift copy differ");
endmodule // lsed_properties
////////////////////////////////////////////////////////////////////////
bind lsed_top lsed_properties u_props (.clk(clk), .rst(rst),
    .serial_clk(serial_clk), .latch_strobe(latch_strobe),
    .gate_n(gate_n), .open_cmp(open_cmp), .short_cmp(short_cmp),
    .sink_output(sink_output), .serial_out(serial_out),
    .in_ready(in_ready));

//--- hw/lsed_params.svh
// Constants for the LED sink driver with on-the-fly fault detection.
`ifndef LSED_PARAMS_SVH
`define LSED_PARAMS_SVH
`define LSED_CH          16
`define LSED_MSB         15
`define LSED_CLK_NS      100
`define LSED_GATE_MIN_NS 120
`define LSED_GATE_CYC    ((`LSED_GATE_MIN_NS + `LSED_CLK_NS - 1)/`LSED_CLK_NS)
`define LSED_SETTLE_NS   200
`define LSED_SETTLE_CYC  ((`LSED_SETTLE_NS + `LSED_CLK_NS - 1)/`LSED_CLK_NS)
`define LSED_WORD_RST    16'h0000
`define LSED_CNT_RST     4'h0
`define LSED_CNT_MAX     4'hf
`define LSED_BUF_DEPTH   2
`define LSED_SYNC_W      36
// The gate bit resets to its idle (off) level, so no false gate follows reset.
`define LSED_SYNC_RST    36'h1_0000_0000
`define LSED_POS_SCLK    35
`define LSED_POS_SDI     34
`define LSED_POS_LATCH   33
`define LSED_POS_GATE    32
`endif

//--- hw/lsed_pkg.sv
// Types shared by the LED sink driver design.
package lsed_pkg;
    typedef logic [15:0] lsed_word_t;   // One bit per sink channel.
    typedef logic [3:0]  lsed_cnt_t;    // Saturating cycle counter.
    typedef logic [1:0]  lsed_fill_t;   // Buffer occupancy, 0 to 2.
endpackage

//--- hw/lsed_top.sv
// LED sink driver core: serial shift, latch, gating and fault reports.
`timescale 1ns/1ns
`include "lsed_params.svh"

module lsed_top
    import lsed_pkg::*;
(
    input  wire logic        clk,            // System clock, 10 MHz.
    input  wire logic        rst,            // Asynchronous reset, high.
    input  wire logic        serial_clk,     // Shift clock pin.
    input  wire logic        serial_in,      // Serial data pin.
    input  wire logic        latch_strobe,   // Latch strobe pin, high.
    input  wire logic        gate_n,         // Output gate pin, low on.
    input  wire logic [15:0] open_cmp,       // Output below open level.
    input  wire logic [15:0] short_cmp,      // Output above short level.
    output logic      [15:0] sink_output,    // Sink enables, high sinks.
    output logic             serial_out,     // Last shift stage.
    output logic             in_ready        // Input buffer has room.
);

    ////////////////////////////////////////////////////////////////////////
    // Rising-edge decode, used for both the shift clock and the strobe.
    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. Every pin passes two flops before use.
    logic [35:0] sync1_r;     // First stage, read only by sync2_r.
    logic [35:0] sync2_r;     // Second stage, safe to use.
    logic [35:0] sync1_nxt;   // Next first stage.
    logic [35:0] sync2_nxt;   // Next second stage.
    logic        sclk_prev_r; // Shift clock one cycle ago.
    logic        la_prev_r;   // Strobe one cycle ago.
    logic        sclk_prev_nxt;
    logic        la_prev_nxt;

    // The comparators are analog and asynchronous, so they are synced too.
    always_comb begin
        sync1_nxt     = {serial_clk, serial_in, latch_strobe, gate_n,
                         open_cmp, short_cmp};
        sync2_nxt     = sync1_r;
        sclk_prev_nxt = sync2_r[`LSED_POS_SCLK];
        la_prev_nxt   = sync2_r[`LSED_POS_LATCH];
    end

    // Register the synchroniser stages.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r     <= `LSED_SYNC_RST;
            sync2_r     <= `LSED_SYNC_RST;
            sclk_prev_r <= 1'b0;
            la_prev_r   <= 1'b0;
        end else begin
            sync1_r     <= sync1_nxt;
            sync2_r     <= sync2_nxt;
            sclk_prev_r <= sclk_prev_nxt;
            la_prev_r   <= la_prev_nxt;
        end
    end

    logic       sclk_rise;  // Shift clock rising edge seen.
    logic       la_rise;    // Strobe rising edge seen.
    logic       gate_on;    // Gate pin is active (low).
    lsed_word_t open_flag;  // Per-channel open comparator.
    lsed_word_t short_flag; // Per-channel short comparator.

    assign sclk_rise = rise(sync2_r[`LSED_POS_SCLK], sclk_prev_r);
    assign la_rise   = rise(sync2_r[`LSED_POS_LATCH], la_prev_r);
    assign gate_on   = ~sync2_r[`LSED_POS_GATE];

    ////////////////////////////////////////////////////////////////////////
    // Two-entry input buffer. It absorbs a shift edge that lands while the
    // shift register is busy taking a fault report, so no bit is lost.
    logic       buf_r [0:1];  // Stored serial bits, entry 0 is oldest.
    logic       buf_nxt [0:1];
    lsed_fill_t fill_r;       // Entries held.
    lsed_fill_t fill_nxt;
    logic       rdy_r;        // Registered room flag.
    logic       rdy_nxt;
    logic       push;         // Edge arrives and room exists.
    logic       pop;          // Shift register takes the oldest bit.
    logic       busy;         // Shift register writes a fault this cycle.

    // Push, pop and shuffle; a pop moves entry 1 down to entry 0.
    always_comb begin
        buf_nxt[0] = buf_r[0];
        buf_nxt[1] = buf_r[1];
        fill_nxt   = fill_r;
        push       = sclk_rise & rdy_r;
        pop        = (fill_r != 2'h0) & ~busy;
        if (pop) begin
            buf_nxt[0] = buf_r[1];
            fill_nxt   = fill_r - 2'h1;
        end
        if (push) begin
            buf_nxt[fill_nxt[0]] = sync2_r[`LSED_POS_SDI];
            fill_nxt             = fill_nxt + 2'h1;
        end
        rdy_nxt = (fill_nxt != 2'h2);
    end

    // Register the buffer.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_r[0] <= 1'b0;
            buf_r[1] <= 1'b0;
            fill_r   <= 2'h0;
            rdy_r    <= 1'b1;
        end else begin
            buf_r[0] <= buf_nxt[0];
            buf_r[1] <= buf_nxt[1];
            fill_r   <= fill_nxt;
            rdy_r    <= rdy_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel fault qualification from the two comparators.
    lsed_word_t latch_r;    // Display latch.
    lsed_word_t open_hit;   // Lit channel reads open.
    lsed_word_t short_hit;  // Dark channel reads short.

    assign open_flag  = sync2_r[31:16];
    assign short_flag = sync2_r[15:0];

    genvar ch;
    generate
        for (ch = 0; ch < `LSED_CH; ch = ch + 1) begin : g_chan
            // Both checks run side by side with no mode select.
            assign open_hit[ch]  = latch_r[ch] & open_flag[ch];
            assign short_hit[ch] = ~latch_r[ch] & short_flag[ch];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Shift register, latch, check timers and fault write-back.
    lsed_word_t sr_r;        // Shift register.
    lsed_word_t sr_nxt;
    lsed_word_t latch_nxt;
    lsed_cnt_t  gate_cnt_r;  // Cycles the gate has been active.
    lsed_cnt_t  gate_cnt_nxt;
    lsed_cnt_t  settle_cnt_r; // Cycles since the last latch load.
    lsed_cnt_t  settle_cnt_nxt;
    logic       open_done_r;  // Open report made for this latch.
    logic       open_done_nxt;
    logic       short_done_r; // Short report made for this latch.
    logic       short_done_nxt;
    logic       settled;      // Outputs have had time to settle.
    logic       gate_long;    // Gate active long enough for open check.
    logic       do_open;      // Write open reports this cycle.
    logic       do_short;     // Write short reports this cycle.
    lsed_word_t out_nxt;
    logic       sout_nxt;

    // One report of each kind per latch load keeps the shifter from being
    // stalled forever by a fault that persists; a fresh load rearms it.
    always_comb begin
        sr_nxt         = sr_r;
        latch_nxt      = latch_r;
        gate_cnt_nxt   = gate_cnt_r;
        settle_cnt_nxt = settle_cnt_r;
        open_done_nxt  = open_done_r;
        short_done_nxt = short_done_r;
        settled   = (settle_cnt_r >= 4'(`LSED_SETTLE_CYC));
        gate_long = (gate_cnt_r >= 4'(`LSED_GATE_CYC));
        do_open   = settled & gate_long & ~open_done_r & ~la_rise;
        do_short  = settled & ~short_done_r & ~la_rise;
        busy      = do_open | do_short;
        // Gate timer counts active cycles and saturates.
        if (!gate_on) begin
            gate_cnt_nxt = `LSED_CNT_RST;
        end else if (gate_cnt_r != `LSED_CNT_MAX) begin
            gate_cnt_nxt = gate_cnt_r + 4'h1;
        end
        if (settle_cnt_r != `LSED_CNT_MAX) begin
            settle_cnt_nxt = settle_cnt_r + 4'h1;
        end
        if (la_rise) begin
            latch_nxt      = sr_r;
            settle_cnt_nxt = `LSED_CNT_RST;
            open_done_nxt  = 1'b0;
            short_done_nxt = 1'b0;
        end else if (busy) begin
            // Faults go straight into the shift copy, never the latch.
            if (do_open) begin
                sr_nxt        = sr_nxt & ~open_hit;
                open_done_nxt = 1'b1;
            end
            if (do_short) begin
                sr_nxt         = sr_nxt | short_hit;
                short_done_nxt = 1'b1;
            end
        end
        if (pop) begin
            sr_nxt = {sr_r[14:0], buf_r[0]};
        end
        // Lit when latched one and gated; dark channels stay off.
        out_nxt  = gate_on ? latch_r : `LSED_WORD_RST;
        sout_nxt = sr_nxt[`LSED_MSB];
    end

    // Register the datapath and outputs.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sr_r         <= `LSED_WORD_RST;
            latch_r      <= `LSED_WORD_RST;
            gate_cnt_r   <= `LSED_CNT_RST;
            settle_cnt_r <= `LSED_CNT_RST;
            open_done_r  <= 1'b1;
            short_done_r <= 1'b1;
            sink_output  <= `LSED_WORD_RST;
            serial_out   <= 1'b0;
        end else begin
            sr_r         <= sr_nxt;
            latch_r      <= latch_nxt;
            gate_cnt_r   <= gate_cnt_nxt;
            settle_cnt_r <= settle_cnt_nxt;
            open_done_r  <= open_done_nxt;
            short_done_r <= short_done_nxt;
            sink_output  <= out_nxt;
            serial_out   <= sout_nxt;
        end
    end

    assign in_ready = rdy_r;

endmodule // lsed_top
